/* pkg/dts_pkg.sv */
package dts_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int DTS_CLK_PERIOD_NS  = 4;
	localparam int DTS_TICK_NS        = 10000;
	localparam int DTS_TICK_CYC       = DTS_TICK_NS / DTS_CLK_PERIOD_NS;
	localparam int DTS_TICKS_PER_MS   = 1000000 / DTS_TICK_NS;
	localparam int DTS_DROPOUT_MAX_US = 1000;
	localparam int DTS_FILT_TICKS     =
		DTS_DROPOUT_MAX_US * 1000 / DTS_TICK_NS + 1;
	localparam int DTS_RESPONSE_MAX_MS = 15;
	localparam int DTS_RESPONSE_CYC   =
		DTS_RESPONSE_MAX_MS * 1000000 / DTS_CLK_PERIOD_NS;
	localparam int DTS_MM_MIN_MS      = 11;
	localparam int DTS_WIN_MAX_MS     = 100;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int           DTS_ADDR_W       = 8;
	localparam int           DTS_DATA_W       = 32;
	localparam logic [7:0]   DTS_CFG_OFS      = 8'h00;
	localparam logic [7:0]   DTS_STAT_OFS     = 8'h04;
	localparam logic [7:0]   DTS_INT_STAT_OFS = 8'h08;
	localparam logic [7:0]   DTS_INT_EN_OFS   = 8'h0C;
	localparam logic [7:0]   DTS_INT_CLR_OFS  = 8'h10;
	localparam int           DTS_CFG_DROP_BIT = 0;
	localparam int           DTS_CFG_MM_LSB   = 8;
	localparam int           DTS_CFG_BLK_LSB  = 16;
	localparam int           DTS_CFG_RM_LSB   = 24;
	localparam int           DTS_CFG_ALM_BIT  = 26;
	localparam int           DTS_CFG_CON_BIT  = 27;
	localparam int           DTS_CFG_STOP_BIT = 28;
	localparam logic [31:0]  DTS_CFG_RESET    = 32'h1100_0000;
	localparam logic [1:0]   DTS_RM_EDGE      = 2'h1;
	localparam logic [1:0]   DTS_RM_LEVEL     = 2'h2;
	localparam logic [7:0]   DTS_ALM_NONE     = 8'h00;
	localparam logic [7:0]   DTS_ALM_DROP     = 8'h68;
	localparam logic [7:0]   DTS_ALM_MISMATCH = 8'h53;
	localparam int           DTS_INT_W        = 4;
	localparam int           DTS_EV_TOFF      = 0;
	localparam int           DTS_EV_DROP      = 1;
	localparam int           DTS_EV_MM        = 2;
	localparam int           DTS_EV_RESTORE   = 3;

	typedef enum logic [1:0] {
		DTS_ST_EXCITED   = 2'h0,
		DTS_ST_TORQUE_OFF = 2'h1,
		DTS_ST_DYN_BRAKE = 2'h3
	} dts_state_t;

	// milliseconds to ticks, window clamped to its top value
	function automatic logic [13:0] dtsMsToTicks(input logic [7:0] ms);
		logic [7:0] lim;
		lim = (ms > 8'(DTS_WIN_MAX_MS)) ? 8'(DTS_WIN_MAX_MS) : ms;
		return 14'(lim) * 14'(DTS_TICKS_PER_MS);
	endfunction : dtsMsToTicks

endpackage : dts_pkg

/* verilog/dts_sync_edge.sv */
`timescale 1ns/10ps
module dts_sync_edge #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk, // clock
	input  wire logic             resetn,   // async reset, low
	input  wire logic [WIDTH-1:0] asyncIn,  // raw inputs
	output logic      [WIDTH-1:0] syncOut,  // synchronised level
	output logic      [WIDTH-1:0] riseOut   // one-cycle rising edge
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] prev_r;

	if (WIDTH < 1) begin : g_chk
		$error("dts_sync_edge: WIDTH must be at least 1");
	end

	// meta_r is read by sync_r only
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
		end else begin
			meta_r <= asyncIn;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign syncOut = sync_r;
	assign riseOut = sync_r & ~prev_r;

endmodule : dts_sync_edge

/* verilog/dts_tick_div.sv */
`timescale 1ns/10ps
module dts_tick_div #(
	parameter int DIV = 2500
) (
	input  wire logic core_clk, // clock
	input  wire logic resetn,   // async reset, low
	output logic      tickOut   // one-cycle pulse every DIV cycles
);
	localparam int CW = $clog2(DIV);

	logic [CW-1:0] cnt_r;

	if (DIV < 2) begin : g_chk
		$error("dts_tick_div: DIV must be at least 2");
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r   <= '0;
			tickOut <= 1'b0;
		end else if (cnt_r == CW'(DIV - 1)) begin
			cnt_r   <= '0;
			tickOut <= 1'b1;
		end else begin
			cnt_r   <= cnt_r + CW'(1);
			tickOut <= 1'b0;
		end
	end

endmodule : dts_tick_div

/* verilog/dts_supervisor.sv */
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
module dts_supervisor
	import dts_pkg::*;
#(
	parameter int TICK_CYC = dts_pkg::DTS_TICK_CYC,
	parameter int RESP_CYC = dts_pkg::DTS_RESPONSE_CYC
) (
	input  wire logic                           core_clk,     // clock
	input  wire logic                           resetn,       // reset, low
	input  wire logic                           safetyInputA, // channel A
	input  wire logic                           safetyInputB, // channel B
	input  wire logic                           excitationRestoreIn, // restore
	input  wire logic                           alarmClearIn, // alarm clear
	input  wire logic                           currentOnIn,  // current on
	input  wire logic                           stopIn,       // stop
	input  wire logic [dts_pkg::DTS_ADDR_W-1:0] regAddr,      // reg address
	input  wire logic [dts_pkg::DTS_DATA_W-1:0] regWrData,    // write data
	input  wire logic                           regWrStb,     // write strobe
	input  wire logic                           regRdStb,     // read strobe
	output logic      [dts_pkg::DTS_DATA_W-1:0] regRdData,    // read data
	output logic                                motorExciteOut, // excited
	output logic                                torqueOffMonitorOut, // monitor
	output logic                                safeTorqueOffOut, // not excited
	output logic                                alarmOut,     // alarm active
	output logic      [7:0]                     alarmCodeOut, // alarm code
	output logic                                irqOut        // interrupt
);
	import dts_pkg::*;
	localparam logic [6:0] FILT_LAST = 7'(DTS_FILT_TICKS - 1);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	if (TICK_CYC < 2) begin : g_chk_tick
		$error("dts_supervisor: TICK_CYC too small");
	end
	if (DTS_FILT_TICKS >= DTS_RESPONSE_MAX_MS * DTS_TICKS_PER_MS)
	begin : g_chk_filt
		$error("dts_supervisor: dropout filter exceeds response time");
	end
	if (RESP_CYC < 1 || RESP_CYC > 4194303) begin : g_chk_resp
		$error("dts_supervisor: RESP_CYC out of range");
	end

	// ------------------------------------------------------------
	// input synchronisation and tick
	// ------------------------------------------------------------
	logic [5:0] syncIn;
	logic [5:0] riseIn;
	logic       tick;
	dts_sync_edge #(
		.WIDTH (6)
	) u_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.asyncIn  ({stopIn, currentOnIn, alarmClearIn,
			excitationRestoreIn, safetyInputB, safetyInputA}),
		.syncOut  (syncIn),
		.riseOut  (riseIn)
	);
	dts_tick_div #(
		.DIV (TICK_CYC)
	) u_tick (
		.core_clk (core_clk),
		.resetn   (resetn),
		.tickOut  (tick)
	);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic                 dropAlmEn_r;
	logic [7:0]           mmMs_r;
	logic [7:0]           blkMs_r;
	logic [1:0]           rmode_r;
	logic                 almClrEn_r;
	logic                 curOnEn_r;
	logic                 stopEn_r;
	logic [DTS_INT_W-1:0] intEn_r;
	logic [DTS_INT_W-1:0] intStat_r;
	logic [DTS_INT_W-1:0] intEv;
	logic [DTS_INT_W-1:0] intClr;
	logic                 wrCfg;
	assign wrCfg  = regWrStb && (regAddr == DTS_CFG_OFS);
	assign intClr = (regWrStb && regAddr == DTS_INT_CLR_OFS) ?
		regWrData[DTS_INT_W-1:0] : '0;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dropAlmEn_r <= DTS_CFG_RESET[DTS_CFG_DROP_BIT];
			mmMs_r      <= DTS_CFG_RESET[DTS_CFG_MM_LSB +: 8];
			blkMs_r     <= DTS_CFG_RESET[DTS_CFG_BLK_LSB +: 8];
			rmode_r     <= DTS_CFG_RESET[DTS_CFG_RM_LSB +: 2];
			almClrEn_r  <= DTS_CFG_RESET[DTS_CFG_ALM_BIT];
			curOnEn_r   <= DTS_CFG_RESET[DTS_CFG_CON_BIT];
			stopEn_r    <= DTS_CFG_RESET[DTS_CFG_STOP_BIT];
		end else if (wrCfg) begin
			dropAlmEn_r <= regWrData[DTS_CFG_DROP_BIT];
			mmMs_r      <= regWrData[DTS_CFG_MM_LSB +: 8];
			blkMs_r     <= regWrData[DTS_CFG_BLK_LSB +: 8];
			rmode_r     <= regWrData[DTS_CFG_RM_LSB +: 2];
			almClrEn_r  <= regWrData[DTS_CFG_ALM_BIT];
			curOnEn_r   <= regWrData[DTS_CFG_CON_BIT];
			stopEn_r    <= regWrData[DTS_CFG_STOP_BIT];
		end
	end

	// sticky events, a new event wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			intEn_r   <= '0;
			intStat_r <= '0;
			irqOut    <= 1'b0;
		end else begin
			if (regWrStb && regAddr == DTS_INT_EN_OFS)
				intEn_r <= regWrData[DTS_INT_W-1:0];
			intStat_r <= (intStat_r & ~intClr) | intEv;
			irqOut    <= |(intStat_r & intEn_r);
		end
	end

	// ------------------------------------------------------------
	// dropout filter
	// ------------------------------------------------------------
	logic [1:0]      chanAct_r;
	logic [1:0]      chanPrev_r;
	logic [1:0][6:0] filtCnt_r;
	logic [1:0]      chanFall;
	logic            bothOn;
	logic            bothOff;
	logic            singleOff;
	// a channel is taken as off only after staying off past the limit
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			chanAct_r  <= 2'h3;
			chanPrev_r <= 2'h3;
			filtCnt_r  <= '0;
		end else begin
			chanPrev_r <= chanAct_r;
			for (int i = 0; i < 2; i++) begin
				if (syncIn[i]) begin
					filtCnt_r[i] <= '0;
					chanAct_r[i] <= 1'b1;
				end else if (tick && chanAct_r[i]) begin
					if (filtCnt_r[i] == FILT_LAST)
						chanAct_r[i] <= 1'b0;
					else
						filtCnt_r[i] <= filtCnt_r[i] + 7'h01;
				end
			end
		end
	end
	assign chanFall  = chanPrev_r & ~chanAct_r;
	assign bothOn    = &chanAct_r;
	assign bothOff   = ~|chanAct_r;
	assign singleOff = ^chanAct_r;

	// ------------------------------------------------------------
	// mismatch window and alarms
	// ------------------------------------------------------------
	logic [13:0] mmCnt_r;
	logic [13:0] mmLimit;
	logic        mmEn;
	logic        mmFire;
	logic        dropFire;
	logic        alarmAct_r;
	assign mmLimit  = dtsMsToTicks(mmMs_r);
	assign mmEn     = mmMs_r >= 8'(DTS_MM_MIN_MS);
	assign mmFire   = mmEn && singleOff && (mmCnt_r >= mmLimit);
	assign dropFire = dropAlmEn_r && (|chanFall);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			mmCnt_r <= '0;
		else if (!singleOff)
			mmCnt_r <= '0;
		else if (tick && mmCnt_r != 14'h3FFF)
			mmCnt_r <= mmCnt_r + 14'h0001;
	end

	// first alarm is latched; alarm clear needs both channels on
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			alarmAct_r   <= 1'b0;
			alarmCodeOut <= DTS_ALM_NONE;
		end else if (!alarmAct_r && dropFire) begin
			alarmAct_r   <= 1'b1;
			alarmCodeOut <= DTS_ALM_DROP;
		end else if (!alarmAct_r && mmFire) begin
			alarmAct_r   <= 1'b1;
			alarmCodeOut <= DTS_ALM_MISMATCH;
		end else if (alarmAct_r && riseIn[3] && bothOn) begin
			alarmAct_r   <= 1'b0;
			alarmCodeOut <= DTS_ALM_NONE;
		end
	end
	assign alarmOut = alarmAct_r;

	// ------------------------------------------------------------
	// excitation state
	// ------------------------------------------------------------
	dts_state_t  state_r;
	dts_state_t  state_nxt;
	logic [13:0] blkCnt_r;
	logic        restInGo;
	logic        otherGo;
	logic        restoreReq;
	assign restInGo = (rmode_r == DTS_RM_LEVEL) ? syncIn[2] : riseIn[2];
	assign otherGo  = (almClrEn_r && riseIn[3])
		|| (curOnEn_r && riseIn[4])
		|| (stopEn_r && riseIn[5]);
	assign restoreReq = bothOn
		&& ((restInGo && blkCnt_r == '0) || otherGo);
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			DTS_ST_EXCITED: begin
				if (bothOff)
					state_nxt = DTS_ST_TORQUE_OFF;
			end
			DTS_ST_TORQUE_OFF: begin
				if (bothOn)
					state_nxt = DTS_ST_DYN_BRAKE;
			end
			DTS_ST_DYN_BRAKE: begin
				if (bothOff)
					state_nxt = DTS_ST_TORQUE_OFF;
				else if (restoreReq)
					state_nxt = DTS_ST_EXCITED;
			end
			default: state_nxt = DTS_ST_TORQUE_OFF;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			state_r <= DTS_ST_EXCITED;
		else
			state_r <= state_nxt;
	end

	// blocking period starts when both channels come back
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			blkCnt_r <= '0;
		else if (state_r == DTS_ST_TORQUE_OFF && bothOn)
			blkCnt_r <= dtsMsToTicks(blkMs_r);
		else if (tick && blkCnt_r != '0)
			blkCnt_r <= blkCnt_r - 14'h0001;
	end

	assign intEv[DTS_EV_TOFF]    = state_r != DTS_ST_TORQUE_OFF
		&& state_nxt == DTS_ST_TORQUE_OFF;
	assign intEv[DTS_EV_DROP]    = dropFire;
	assign intEv[DTS_EV_MM]      = mmFire;
	assign intEv[DTS_EV_RESTORE] = state_r == DTS_ST_DYN_BRAKE
		&& state_nxt == DTS_ST_EXCITED;

	// ------------------------------------------------------------
	// outputs and read port
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			motorExciteOut      <= 1'b1;
			torqueOffMonitorOut <= 1'b0;
			safeTorqueOffOut    <= 1'b0;
		end else begin
			motorExciteOut      <= state_nxt == DTS_ST_EXCITED;
			torqueOffMonitorOut <= bothOff;
			safeTorqueOffOut    <= state_nxt != DTS_ST_EXCITED;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			regRdData <= '0;
		else if (!regRdStb)
			regRdData <= '0;
		else begin
			case (regAddr)
				DTS_CFG_OFS: regRdData <= {3'h0, stopEn_r, curOnEn_r,
					almClrEn_r, rmode_r, blkMs_r, mmMs_r, 7'h00,
					dropAlmEn_r};
				DTS_STAT_OFS: regRdData <= {16'h0000, alarmCodeOut,
					2'h0, alarmAct_r, torqueOffMonitorOut,
					state_r == DTS_ST_DYN_BRAKE,
					state_r == DTS_ST_EXCITED, chanAct_r};
				DTS_INT_STAT_OFS: regRdData <= 32'(intStat_r);
				DTS_INT_EN_OFS:   regRdData <= 32'(intEn_r);
				default:          regRdData <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	logic [21:0] offWait_r;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			offWait_r <= '0;
		else if (syncIn[1:0] != 2'h0 || safeTorqueOffOut)
			offWait_r <= '0;
		else
			offWait_r <= offWait_r + 22'h000001;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	AST_MON_QUIET: assert property (
		(motorExciteOut && bothOn) |=> !torqueOffMonitorOut)
		else $error("monitor on while excited with both channels on");
	AST_TORQUE_OFF: assert property (
		bothOff |=> (!motorExciteOut && torqueOffMonitorOut))
		else $error("both channels off but torque not removed");
	AST_DROP_ALARM: assert property (
		(dropAlmEn_r && (|chanFall) && !alarmAct_r)
		|=> (alarmOut && alarmCodeOut == DTS_ALM_DROP))
		else $error("drop alarm missing or wrong code");
	AST_NO_DROP_ALARM: assert property (
		(!dropAlmEn_r && !alarmAct_r && !mmFire) |=> !alarmOut)
		else $error("alarm raised with drop alarm disabled");
	AST_MISMATCH: assert property (
		(mmEn && singleOff && mmCnt_r == mmLimit && !alarmAct_r
		&& !dropFire) |=> (alarmOut && alarmCodeOut == DTS_ALM_MISMATCH))
		else $error("mismatch alarm missing or wrong code");
	AST_MM_DISABLED: assert property (
		(mmMs_r <= 8'(DTS_MM_MIN_MS - 1)) |-> !mmFire)
		else $error("mismatch check active in disabled range");
	AST_BLOCKED: assert property (
		(state_r == DTS_ST_DYN_BRAKE && blkCnt_r != '0 && !otherGo)
		|=> !motorExciteOut)
		else $error("restore input acted during blocking period");
	AST_LEVEL: assert property (
		(state_r == DTS_ST_DYN_BRAKE && bothOn && rmode_r == DTS_RM_LEVEL
		&& syncIn[2] && blkCnt_r == '0) |=> motorExciteOut)
		else $error("level restore did not excite");
	AST_ALM_CLR: assert property (
		(state_r == DTS_ST_DYN_BRAKE && bothOn && almClrEn_r
		&& riseIn[3]) |=> motorExciteOut)
		else $error("alarm clear edge did not excite");
	AST_CUR_ON: assert property (
		(state_r == DTS_ST_DYN_BRAKE && bothOn && curOnEn_r
		&& riseIn[4]) |=> motorExciteOut)
		else $error("current on edge did not excite");
	AST_STOP: assert property (
		(state_r == DTS_ST_DYN_BRAKE && bothOn && stopEn_r
		&& riseIn[5]) |=> motorExciteOut)
		else $error("stop edge did not excite");
	AST_FILTER: assert property (
		$fell(chanAct_r[0]) |-> ($past(filtCnt_r[0]) == FILT_LAST))
		else $error("channel dropped before dropout limit");
	AST_RESPONSE: assert property (
		offWait_r < 22'(RESP_CYC))
		else $error("torque off not reached in response time");
endmodule : dts_supervisor

/* dv/dts_safety_partner.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// external safety module: two channels, high = on
// ------------------------------------------------------------
module dts_safety_partner #(
	parameter int MIN_OFF = 7500, // shortest off time, 15 ms
	parameter int PULSE   = 500   // diagnosis pulse width, 1 ms
) (
	input  wire logic       core_clk,     // clock
	input  wire logic [1:0] offReq,       // off request, bit0 channel A
	input  wire logic       testPulse,    // start one diagnosis pulse
	output logic            safetyInputA, // channel A
	output logic            safetyInputB  // channel B
);
	int         offCnt [2];
	int         pulseCnt;
	logic [1:0] lvl;

	initial begin
		offCnt[0] = 0;
		offCnt[1] = 0;
		pulseCnt  = 0;
		lvl       = 2'h3;
	end

	assign safetyInputA = lvl[0];
	assign safetyInputB = lvl[1];

	// a released channel stays off until its shortest off time ran out
	always @(posedge core_clk) begin
		if (testPulse)
			pulseCnt <= PULSE;
		else if (pulseCnt > 0)
			pulseCnt <= pulseCnt - 1;
		for (int i = 0; i < 2; i++) begin
			if (offReq[i])
				offCnt[i] <= MIN_OFF;
			else if (offCnt[i] > 0)
				offCnt[i] <= offCnt[i] - 1;
			lvl[i] <= !(offReq[i] || offCnt[i] > 1 || testPulse
				|| pulseCnt > 1);
		end
	end
endmodule : dts_safety_partner

/* dv/testbench.sv */
`timescale 1ns/10ps
module testbench;
	import dts_pkg::*;
	localparam int TICK = 5;
	localparam int MS   = DTS_TICKS_PER_MS * TICK;
	localparam int RESP = DTS_RESPONSE_MAX_MS * MS;
	logic        core_clk;
	logic        resetn;
	logic [1:0]  offReq;
	logic        testPulse;
	logic        safetyInputA;
	logic        safetyInputB;
	logic [3:0]  srcIn; // alarm clear, current on, stop, restore
	logic [7:0]  regAddr;
	logic [31:0] regWrData;
	logic        regWrStb;
	logic        regRdStb;
	logic [31:0] regRdData;
	logic        motorExciteOut;
	logic        torqueOffMonitorOut;
	logic        safeTorqueOffOut;
	logic        alarmOut;
	logic [7:0]  alarmCodeOut;
	logic        irqOut;
	logic [31:0] rd;
	int          err_total;
	int          comparisons;

	dts_safety_partner #(.MIN_OFF(RESP), .PULSE(MS)) partner (
		.core_clk(core_clk), .offReq(offReq), .testPulse(testPulse),
		.safetyInputA(safetyInputA), .safetyInputB(safetyInputB));

	dts_supervisor #(.TICK_CYC(TICK), .RESP_CYC(RESP)) uut (
		.core_clk(core_clk), .resetn(resetn),
		.safetyInputA(safetyInputA), .safetyInputB(safetyInputB),
		.excitationRestoreIn(srcIn[3]), .alarmClearIn(srcIn[0]),
		.currentOnIn(srcIn[1]), .stopIn(srcIn[2]),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
		.regRdStb(regRdStb), .regRdData(regRdData),
		.motorExciteOut(motorExciteOut),
		.torqueOffMonitorOut(torqueOffMonitorOut),
		.safeTorqueOffOut(safeTorqueOffOut), .alarmOut(alarmOut),
		.alarmCodeOut(alarmCodeOut), .irqOut(irqOut));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ------------------------------------------------------------
	// bus and check tasks
	// ------------------------------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr   <= a;
		regWrData <= d;
		regWrStb  <= 1'b1;
		@(posedge core_clk);
		regWrStb  <= 1'b0;
	endtask : regWrite

	task automatic regRead(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regAddr  <= a;
		regRdStb <= 1'b1;
		@(posedge core_clk);
		regRdStb <= 1'b0;
		#1;
		d = regRdData;
	endtask : regRead

	task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: word %h not %h", $time, got, exp);
		end
	endtask : chkWord

	task automatic chkBit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: bit %b not %b", $time, got, exp);
		end
	endtask : chkBit

	// sel 0 monitor, 1 excitation, 2 alarm
	task automatic waitBit(input int sel, input logic val, input int lim);
		int   n;
		logic s;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			s = sel == 0 ? torqueOffMonitorOut
				: sel == 1 ? motorExciteOut : alarmOut;
			n++;
		end while (s !== val && n < lim);
		if (s !== val) begin
			err_total++;
			$display("mismatch at %0t: wait on %0d ran out", $time, sel);
			print_verdict();
		end
	endtask : waitBit

	task automatic pulseIn(input int i);
		@(posedge core_clk);
		srcIn[i] <= 1'b1;
		repeat (4) @(posedge core_clk);
		srcIn[i] <= 1'b0;
		repeat (10) @(posedge core_clk);
		#1;
	endtask : pulseIn

	// both channels off, then back on into the waiting state
	task automatic torqueOff();
		@(posedge core_clk);
		offReq <= 2'h3;
		waitBit(0, 1'b1, RESP);
		chkBit(motorExciteOut, 1'b0);
		chkBit(safeTorqueOffOut, 1'b1);
		offReq <= 2'h0;
		waitBit(0, 1'b0, RESP + MS);
	endtask : torqueOff

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{offReq, testPulse, srcIn, regAddr, regWrData} = '0;
		{regWrStb, regRdStb, resetn} = '0;
		err_total   = 0;
		comparisons = 0;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		regRead(DTS_CFG_OFS, rd);
		chkWord(rd, DTS_CFG_RESET);
		regRead(8'h40, rd);
		chkWord(rd, 32'h0);
		chkBit(motorExciteOut, 1'b1);
		chkBit(torqueOffMonitorOut, 1'b0);
		@(posedge core_clk);
		testPulse <= 1'b1;
		@(posedge core_clk);
		testPulse <= 1'b0;
		repeat (2 * MS) @(posedge core_clk);
		#1;
		chkBit(motorExciteOut, 1'b1);
		chkBit(torqueOffMonitorOut, 1'b0);
		$display("test reset and pulse done");
		regWrite(DTS_INT_EN_OFS, 32'h1);
		regWrite(DTS_CFG_OFS, 32'h1102_0000);
		torqueOff();
		chkBit(irqOut, 1'b1);
		regRead(DTS_INT_STAT_OFS, rd);
		chkWord(rd, 32'h1);
		regWrite(DTS_INT_CLR_OFS, 32'hF);
		regRead(DTS_INT_STAT_OFS, rd);
		chkWord(rd, 32'h0);
		chkBit(irqOut, 1'b0);
		pulseIn(3);
		chkBit(motorExciteOut, 1'b0);
		repeat (2 * MS) @(posedge core_clk);
		pulseIn(3);
		waitBit(1, 1'b1, 20);
		chkBit(safeTorqueOffOut, 1'b0);
		$display("test edge restore done");
		regWrite(DTS_CFG_OFS, 32'h0200_0000);
		srcIn[3] <= 1'b1;
		torqueOff();
		waitBit(1, 1'b1, 20);
		srcIn[3] <= 1'b0;
		$display("test level restore done");
		for (int i = 0; i < 3; i++) begin
			regWrite(DTS_CFG_OFS, 32'h0100_0000);
			torqueOff();
			pulseIn(i);
			chkBit(motorExciteOut, 1'b0);
			regWrite(DTS_CFG_OFS, 32'h0100_0000 | (32'h1 << (26 + i)));
			pulseIn(i);
			waitBit(1, 1'b1, 20);
		end
		$display("test other restore sources done");
		regWrite(DTS_CFG_OFS, 32'h0100_0001);
		@(posedge core_clk);
		offReq <= 2'h1;
		waitBit(2, 1'b1, RESP);
		chkWord({24'h0, alarmCodeOut}, {24'h0, DTS_ALM_DROP});
		chkBit(motorExciteOut, 1'b1);
		offReq <= 2'h0;
		repeat (RESP + 50) @(posedge core_clk);
		pulseIn(0);
		waitBit(2, 1'b0, 20);
		$display("test drop alarm done");
		regWrite(DTS_CFG_OFS, 32'h0100_0A00);
		@(posedge core_clk);
		offReq <= 2'h1;
		repeat (13 * MS) @(posedge core_clk);
		#1;
		chkBit(alarmOut, 1'b0);
		offReq <= 2'h0;
		repeat (RESP + 50) @(posedge core_clk);
		regWrite(DTS_CFG_OFS, 32'h0100_0B00);
		offReq <= 2'h1;
		repeat (11 * MS) @(posedge core_clk);
		#1;
		chkBit(alarmOut, 1'b0);
		waitBit(2, 1'b1, 2 * MS);
		chkWord({24'h0, alarmCodeOut}, {24'h0, DTS_ALM_MISMATCH});
		$display("test mismatch alarm done");
		regRead(DTS_STAT_OFS, rd);
		chkWord(rd, 32'h0000_5326);
		regRead(DTS_INT_STAT_OFS, rd);
		chkWord(rd, 32'h0000_000F);
		regWrite(DTS_INT_CLR_OFS, 32'h0000_000F);
		regRead(DTS_INT_STAT_OFS, rd);
		chkWord(rd, 32'h0000_0004);
		chkBit(irqOut, 1'b0);
		regWrite(DTS_INT_EN_OFS, 32'h0000_0004);
		regRead(DTS_INT_EN_OFS, rd);
		chkWord(rd, 32'h0000_0004);
		chkBit(irqOut, 1'b1);
		$display("test status and events done");
		print_verdict();
	end
endmodule : testbench
